// file: core/sysctl_pkg.sv
// Constants for the system control register bank
package sysctl_pkg;
  // Coprocessor primary register numbers
  localparam logic [3:0] CRN_CONTROL    = 4'h1;
  localparam logic [3:0] CRN_TABLE_BASE = 4'h2;
  localparam logic [3:0] CRN_DOMAIN     = 4'h3;
  // Control register field positions
  localparam int BIT_PC_LOAD   = 15;
  localparam int BIT_REPLACE   = 14;
  localparam int BIT_VECTOR    = 13;
  localparam int BIT_ICACHE    = 12;
  localparam int BIT_ROM_PROT  = 9;
  localparam int BIT_SYS_PROT  = 8;
  localparam int BIT_ENDIAN    = 7;
  localparam int BIT_DCACHE    = 2;
  localparam int BIT_ALIGN     = 1;
  localparam int BIT_MMU       = 0;
  // Fixed read pattern of reserved control bits (18, 16, 6:3 read one)
  localparam logic [31:0] CTRL_FIXED_ONES = 32'h0005_0078;
  // Writable control bits
  localparam logic [31:0] CTRL_WR_MASK    = 32'h0000_f387;
  // Table pointer field
  localparam int TABLE_LSB = 14;
  localparam logic [31:0] TABLE_MASK      = 32'hffff_c000;
  // Exception vector bases
  localparam logic [31:0] VEC_BASE_LOW    = 32'h0000_0000;
  localparam logic [31:0] VEC_BASE_HIGH   = 32'hffff_0000;
  // Domain access codes
  typedef enum logic [1:0] {
    DOM_NO_ACCESS = 2'b00,
    DOM_CLIENT    = 2'b01,
    DOM_RESERVED  = 2'b10,
    DOM_MANAGER   = 2'b11
  } domain_code_type;
  localparam int DOMAIN_COUNT = 16;
endpackage

// file: core/sysctl_cache_mmu_regs.sv
// System control register bank: control, table base and domain access registers
`timescale 1ns/1ps
`default_nettype none
module sysctl_cache_mmu_regs (
  // Clock and reset
  input  wire  logic        clock_i,
  input  wire  logic        rst_i,
  // Initialisation straps
  input  wire  logic        vector_init_input_i,
  input  wire  logic        endian_init_input_i,
  // Coprocessor register transfer from the core
  input  wire  logic        cp_write_i,
  input  wire  logic        cp_read_i,
  input  wire  logic [3:0]  cp_major_reg_i,
  input  wire  logic [3:0]  coproc_minor_reg_i,
  input  wire  logic [2:0]  cp_opcode2_i,
  input  wire  logic [31:0] cp_wdata_i,
  output var   logic [31:0] cp_rdata_o,
  output var   logic        cp_rvalid_o,
  // Control outputs to the core and caches
  output var   logic        pc_load_state_ctl_o,
  output var   logic        replace_policy_sel_o,
  output var   logic [31:0] vector_base_o,
  output var   logic        big_endian_o,
  output var   logic        align_check_o,
  output var   logic        mmu_enable_o,
  output var   logic        rom_prot_o,
  output var   logic        sys_prot_o,
  output var   logic [31:0] table_base_reg_o,
  output var   logic [31:0] domain_access_o,
  // Cache access policy outputs
  output var   logic        icache_access_o,
  output var   logic        icache_force_cacheable_o,
  output var   logic        dcache_access_o,
  output var   logic        dcache_force_uncached_o,
  output var   logic        translate_en_o,
  output var   logic        perm_check_en_o
);
  import sysctl_pkg::*;

  // Strap synchronisers, three stages each
  logic [2:0] vec_sync_q;
  logic [2:0] end_sync_q;
  logic [2:0] fill_q;
  logic       strap_loaded_q;
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] table_q;
  logic [31:0] domain_q;
  logic [31:0] rdata_d;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      vec_sync_q <= 3'h0;
      end_sync_q <= 3'h0;
      fill_q     <= 3'h0;
    end else begin
      vec_sync_q <= {vec_sync_q[1:0], vector_init_input_i};
      end_sync_q <= {end_sync_q[1:0], endian_init_input_i};
      fill_q     <= {fill_q[1:0], 1'b1};
    end
  end

  // Stages hold reset zeros at first; agreement counts only once filled
  logic sync_full;
  assign sync_full = fill_q[2];

  // Strap levels count once second and third stages agree
  logic vec_strap;
  logic end_strap;
  logic vec_agree;
  logic end_agree;
  assign vec_agree = (vec_sync_q[1] == vec_sync_q[2]);
  assign end_agree = (end_sync_q[1] == end_sync_q[2]);
  assign vec_strap = vec_sync_q[2];
  assign end_strap = end_sync_q[2];

  // Register selects; table base write ignores minor and opcode fields
  logic sel_ctrl;
  logic sel_table;
  logic sel_domain;
  assign sel_ctrl   = (cp_major_reg_i == CRN_CONTROL);
  assign sel_table  = (cp_major_reg_i == CRN_TABLE_BASE);
  assign sel_domain = (cp_major_reg_i == CRN_DOMAIN);

  // Control next value: masked write keeps reserved bits fixed
  logic [31:0] ctrl_written;
  assign ctrl_written = (cp_wdata_i & CTRL_WR_MASK) | CTRL_FIXED_ONES;
  assign ctrl_d = (cp_write_i && sel_ctrl) ? ctrl_written : ctrl_q;

  // Control register; straps loaded after reset release
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q         <= CTRL_FIXED_ONES;
      strap_loaded_q <= 1'b0;
    end else if (!strap_loaded_q) begin
      if (sync_full && vec_agree && end_agree) begin
        ctrl_q[BIT_VECTOR] <= vec_strap;
        ctrl_q[BIT_ENDIAN] <= end_strap;
        strap_loaded_q     <= 1'b1;
      end
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Table base and domain registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      table_q  <= 32'h0;
      domain_q <= 32'h0;
    end else begin
      if (cp_write_i && sel_table) begin
        table_q <= cp_wdata_i & TABLE_MASK;
      end
      if (cp_write_i && sel_domain) begin
        domain_q <= cp_wdata_i;
      end
    end
  end

  // Read mux; table low bits read zero
  always_comb begin
    rdata_d = 32'h0;
    if (sel_ctrl) begin
      rdata_d = ctrl_q;
    end else if (sel_table) begin
      rdata_d = table_q & TABLE_MASK;
    end else if (sel_domain) begin
      rdata_d = domain_q;
    end
  end

  // Cache and MMU policy from control bits
  logic ic_on;
  logic dc_on;
  logic mmu_on;
  assign ic_on  = ctrl_q[BIT_ICACHE];
  assign dc_on  = ctrl_q[BIT_DCACHE];
  assign mmu_on = ctrl_q[BIT_MMU];

  // Registered outputs
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cp_rdata_o               <= 32'h0;
      cp_rvalid_o              <= 1'b0;
      pc_load_state_ctl_o      <= 1'b0;
      replace_policy_sel_o     <= 1'b0;
      vector_base_o            <= VEC_BASE_LOW;
      big_endian_o             <= 1'b0;
      align_check_o            <= 1'b0;
      mmu_enable_o             <= 1'b0;
      rom_prot_o               <= 1'b0;
      sys_prot_o               <= 1'b0;
      table_base_reg_o         <= 32'h0;
      domain_access_o          <= 32'h0;
      icache_access_o          <= 1'b0;
      icache_force_cacheable_o <= 1'b0;
      dcache_access_o          <= 1'b0;
      dcache_force_uncached_o  <= 1'b0;
      translate_en_o           <= 1'b0;
      perm_check_en_o          <= 1'b0;
    end else begin
      cp_rdata_o               <= cp_read_i ? rdata_d : 32'h0;
      cp_rvalid_o              <= cp_read_i;
      pc_load_state_ctl_o      <= ctrl_q[BIT_PC_LOAD];
      replace_policy_sel_o     <= ctrl_q[BIT_REPLACE];
      vector_base_o            <= ctrl_q[BIT_VECTOR] ? VEC_BASE_HIGH : VEC_BASE_LOW;
      big_endian_o             <= ctrl_q[BIT_ENDIAN];
      align_check_o            <= ctrl_q[BIT_ALIGN];
      mmu_enable_o             <= mmu_on;
      rom_prot_o               <= ctrl_q[BIT_ROM_PROT];
      sys_prot_o               <= ctrl_q[BIT_SYS_PROT];
      table_base_reg_o         <= table_q;
      domain_access_o          <= domain_q;
      icache_access_o          <= ic_on;
      icache_force_cacheable_o <= ic_on && !mmu_on;
      dcache_access_o          <= dc_on;
      dcache_force_uncached_o  <= dc_on && !mmu_on;
      translate_en_o           <= mmu_on;
      perm_check_en_o          <= mmu_on && (ic_on || dc_on);
    end
  end

  // Assertions
  sequence ctrl_wr_s;
    strap_loaded_q && cp_write_i && sel_ctrl;
  endsequence

  sequence two_edges_s;
    ##2 1'b1;
  endsequence

  chk_mmu_follow: assert property (@(posedge clock_i) disable iff (rst_i)
    ctrl_wr_s |-> two_edges_s and ##2 (mmu_enable_o == $past(cp_wdata_i[BIT_MMU], 2)))
    else $error("mmu enable did not follow write");
  chk_dcache_follow: assert property (@(posedge clock_i) disable iff (rst_i)
    ctrl_wr_s |-> ##2 (dcache_access_o == $past(cp_wdata_i[BIT_DCACHE], 2)))
    else $error("data cache enable did not follow write");
  chk_icache_follow: assert property (@(posedge clock_i) disable iff (rst_i)
    ctrl_wr_s |-> ##2 (icache_access_o == $past(cp_wdata_i[BIT_ICACHE], 2)))
    else $error("instruction cache enable did not follow write");
  chk_vector_base: assert property (@(posedge clock_i) disable iff (rst_i)
    ctrl_wr_s |-> ##2 (vector_base_o == ($past(cp_wdata_i[BIT_VECTOR], 2) ? VEC_BASE_HIGH : VEC_BASE_LOW)))
    else $error("vector base wrong after write");
  chk_ctrl_fixed: assert property (@(posedge clock_i) disable iff (rst_i)
    (ctrl_q & ~CTRL_WR_MASK) == CTRL_FIXED_ONES)
    else $error("reserved control bits changed");
  chk_table_write: assert property (@(posedge clock_i) disable iff (rst_i)
    cp_write_i && sel_table |=> (table_q == ($past(cp_wdata_i) & TABLE_MASK)))
    else $error("table base not updated");
  chk_table_read: assert property (@(posedge clock_i) disable iff (rst_i)
    cp_read_i && sel_table && !cp_write_i |=> cp_rvalid_o && (cp_rdata_o[31:14] == $past(table_q[31:14])))
    else $error("table base read wrong");
  chk_domain_rw: assert property (@(posedge clock_i) disable iff (rst_i)
    cp_write_i && sel_domain |=> ##1 (domain_access_o == $past(cp_wdata_i, 2)))
    else $error("domain register not replaced");
  chk_flat_icache: assert property (@(posedge clock_i) disable iff (rst_i)
    icache_force_cacheable_o |-> !translate_en_o && icache_access_o)
    else $error("instruction flat mode inconsistent");
  chk_flat_dcache: assert property (@(posedge clock_i) disable iff (rst_i)
    dcache_force_uncached_o |-> !translate_en_o && dcache_access_o)
    else $error("data flat mode inconsistent");
  chk_strap_load: assert property (@(posedge clock_i) disable iff (rst_i)
    !strap_loaded_q && sync_full && vec_agree && end_agree |=> ctrl_q[BIT_VECTOR] == $past(vec_sync_q[2]))
    else $error("vector strap not loaded");

  // Remaining control bits reach their outputs two edges after a write
  chk_pc_load_follow: assert property (@(posedge clock_i) disable iff (rst_i)
    ctrl_wr_s |-> ##2 (pc_load_state_ctl_o == $past(cp_wdata_i[BIT_PC_LOAD], 2)))
    else $error("program counter load control did not follow write");
  chk_replace_follow: assert property (@(posedge clock_i) disable iff (rst_i)
    ctrl_wr_s |-> ##2 (replace_policy_sel_o == $past(cp_wdata_i[BIT_REPLACE], 2)))
    else $error("replacement select did not follow write");
  chk_endian_follow: assert property (@(posedge clock_i) disable iff (rst_i)
    ctrl_wr_s |-> ##2 (big_endian_o == $past(cp_wdata_i[BIT_ENDIAN], 2)))
    else $error("byte order did not follow write");
  chk_align_follow: assert property (@(posedge clock_i) disable iff (rst_i)
    ctrl_wr_s |-> ##2 (align_check_o == $past(cp_wdata_i[BIT_ALIGN], 2)))
    else $error("alignment check did not follow write");
  chk_rom_follow: assert property (@(posedge clock_i) disable iff (rst_i)
    ctrl_wr_s |-> ##2 (rom_prot_o == $past(cp_wdata_i[BIT_ROM_PROT], 2)))
    else $error("read-only protection did not follow write");
  chk_sys_follow: assert property (@(posedge clock_i) disable iff (rst_i)
    ctrl_wr_s |-> ##2 (sys_prot_o == $past(cp_wdata_i[BIT_SYS_PROT], 2)))
    else $error("system protection did not follow write");
  chk_translate_follow: assert property (@(posedge clock_i) disable iff (rst_i)
    ctrl_wr_s |-> ##2 (translate_en_o == $past(cp_wdata_i[BIT_MMU], 2)))
    else $error("translation enable did not follow write");
  chk_perm_follow: assert property (@(posedge clock_i) disable iff (rst_i)
    ctrl_wr_s |-> ##2 (perm_check_en_o == ($past(cp_wdata_i[BIT_MMU], 2)
      && ($past(cp_wdata_i[BIT_ICACHE], 2) || $past(cp_wdata_i[BIT_DCACHE], 2)))))
    else $error("permission check enable did not follow write");

  // Read return: one-cycle valid, data from the selected register
  chk_rvalid_pulse: assert property (@(posedge clock_i) disable iff (rst_i)
    cp_read_i |=> cp_rvalid_o)
    else $error("read valid missing");
  chk_rdata_idle: assert property (@(posedge clock_i) disable iff (rst_i)
    !cp_read_i |=> !cp_rvalid_o && (cp_rdata_o == 32'h0))
    else $error("read return active without read");
  chk_domain_read: assert property (@(posedge clock_i) disable iff (rst_i)
    cp_read_i && sel_domain |=> (cp_rdata_o == $past(domain_q)))
    else $error("domain register read wrong");
  chk_ctrl_read: assert property (@(posedge clock_i) disable iff (rst_i)
    cp_read_i && sel_ctrl |=> (cp_rdata_o == $past(ctrl_q)))
    else $error("control register read wrong");
  chk_unmapped_read: assert property (@(posedge clock_i) disable iff (rst_i)
    cp_read_i && !sel_ctrl && !sel_table && !sel_domain |=> (cp_rdata_o == 32'h0))
    else $error("unmapped register read not zero");

  // Table pointer never holds bits below its field
  chk_table_low_zero: assert property (@(posedge clock_i) disable iff (rst_i)
    (table_q & ~TABLE_MASK) == 32'h0)
    else $error("table base low bits not zero");
endmodule
`default_nettype wire

// file: test/core_xfer_model.sv
// Core side model issuing coprocessor register transfers
`timescale 1ns/1ps
`default_nettype none
module core_xfer_model (
  // Clock and read return
  input  wire logic        clock_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic        rvalid_i,
  // Transfer request
  output var  logic        wr_o,
  output var  logic        rd_o,
  output var  logic [3:0]  major_o,
  output var  logic [3:0]  minor_o,
  output var  logic [2:0]  op2_o,
  output var  logic [31:0] wdata_o
);
  // Idle request; minor and opcode2 stay zero
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    major_o = 4'h0;
    minor_o = 4'h0;
    op2_o = 3'h0;
    wdata_o = 32'h0;
  end
  // One-cycle write; released data flips
  task automatic put(input logic [3:0] r, input logic [31:0] d);
    @(posedge clock_i);
    wr_o <= 1'b1;
    major_o <= r;
    wdata_o <= d;
    @(posedge clock_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  // One-cycle read, answer taken a cycle later
  task automatic get(input logic [3:0] r, output logic [31:0] d, output logic v);
    @(posedge clock_i);
    rd_o <= 1'b1;
    major_o <= r;
    @(posedge clock_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
    v = rvalid_i;
  endtask
endmodule
`default_nettype wire

// file: test/sysctl_cache_mmu_regs_test.sv
// Testbench for the system control register bank
`timescale 1ns/1ps
`default_nettype none
module sysctl_cache_mmu_regs_test;
  import sysctl_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        vinit = 1'b1;
  logic        einit = 1'b1;
  logic        wr, rd, rv, pcl, rpl, bige, alg, mmu, romp, sysp, ia, ifc, da, dfu, tre, pce;
  logic [3:0]  maj, mnr;
  logic [2:0]  op2;
  logic [31:0] wd, rdat, vb, tbr, dom;
  int          fails = 0;
  int          checks_done = 0;
  wire  [9:0]  ctl_v = {pcl, rpl, vb == VEC_BASE_HIGH, ia, romp, sysp, bige, da, alg, mmu};
  wire  [5:0]  pol_v = {ia, da, ifc, dfu, tre, pce};
  // 125 MHz clock
  always #4 clock_i = ~clock_i;
  // Device and core model
  sysctl_cache_mmu_regs u_sysctl_cache_mmu_regs (
    .clock_i(clock_i), .rst_i(rst_i), .vector_init_input_i(vinit), .endian_init_input_i(einit),
    .cp_write_i(wr), .cp_read_i(rd), .cp_major_reg_i(maj), .coproc_minor_reg_i(mnr),
    .cp_opcode2_i(op2), .cp_wdata_i(wd), .cp_rdata_o(rdat), .cp_rvalid_o(rv),
    .pc_load_state_ctl_o(pcl), .replace_policy_sel_o(rpl), .vector_base_o(vb), .big_endian_o(bige),
    .align_check_o(alg), .mmu_enable_o(mmu), .rom_prot_o(romp), .sys_prot_o(sysp),
    .table_base_reg_o(tbr), .domain_access_o(dom), .icache_access_o(ia), .icache_force_cacheable_o(ifc),
    .dcache_access_o(da), .dcache_force_uncached_o(dfu), .translate_en_o(tre), .perm_check_en_o(pce));
  core_xfer_model u_core_xfer_model (
    .clock_i(clock_i), .rdata_i(rdat), .rvalid_i(rv), .wr_o(wr), .rd_o(rd), .major_o(maj),
    .minor_o(mnr), .op2_o(op2), .wdata_o(wd));
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Read a register and compare masked data
  task automatic rd_chk(input logic [3:0] r, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic        v;
    u_core_xfer_model.get(r, d, v);
    check({31'h0, v}, 32'h1);
    check(d & m, e);
  endtask
  // Let a write reach the outputs
  task automatic settle;
    @(posedge clock_i);
    #1;
  endtask
  task automatic t_reset;
    repeat (6) @(posedge clock_i);
    #1;
    check(vb, VEC_BASE_HIGH);
    check({31'h0, bige}, 32'h1);
    check({26'h0, pol_v}, 32'h0);
    rd_chk(CRN_CONTROL, 32'hffff_ffff, CTRL_FIXED_ONES | 32'h0000_2080);
  endtask
  // Walk one control bit at a time
  task automatic t_bits;
    int bl[10] = '{15, 14, 13, 12, 9, 8, 7, 2, 1, 0};
    for (int i = 0; i < 10; i++) begin
      u_core_xfer_model.put(CRN_CONTROL, (32'h1 << bl[i]) | 32'h78);
      settle();
      check({22'h0, ctl_v}, 32'h200 >> i);
      rd_chk(CRN_CONTROL, 32'hffff_ffff, (32'h1 << bl[i]) | CTRL_FIXED_ONES);
    end
  endtask
  // Every cache and MMU enable combination
  task automatic t_policy;
    for (int k = 0; k < 8; k++) begin
      u_core_xfer_model.put(CRN_CONTROL, 32'h78 | {19'h0, k[2], 9'h0, k[1], 1'b0, k[0]});
      settle();
      check({26'h0, pol_v}, {26'h0, k[2], k[1], k[2] & ~k[0], k[1] & ~k[0], k[0], k[0] & (k[2] | k[1])});
      rd_chk(CRN_CONTROL, 32'hffff_ffff, CTRL_FIXED_ONES | {19'h0, k[2], 9'h0, k[1], 1'b0, k[0]});
      // No dirty lines exist here before data cache disable
    end
  endtask
  task automatic t_tables;
    u_core_xfer_model.put(CRN_TABLE_BASE, 32'hfedc_c000);
    u_core_xfer_model.put(CRN_DOMAIN, 32'h1b1b_e4e4);
    settle();
    check(tbr, 32'hfedc_c000);
    check(dom, 32'h1b1b_e4e4);
    rd_chk(CRN_TABLE_BASE, TABLE_MASK, 32'hfedc_c000);
    rd_chk(CRN_DOMAIN, 32'hffff_ffff, 32'h1b1b_e4e4);
  endtask
  // Unmapped numbers leave the bank alone
  task automatic t_unmapped;
    u_core_xfer_model.put(4'h5, 32'hffff_ffff);
    rd_chk(4'h4, 32'hffff_ffff, 32'h0);
    rd_chk(CRN_CONTROL, 32'hffff_ffff, CTRL_FIXED_ONES | 32'h0000_1005);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    t_reset();
    t_bits();
    t_policy();
    t_tables();
    t_unmapped();
    end_sim();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clock_i);
    fails++;
    end_sim();
  end
endmodule
`default_nettype wire
